// File: common/wmu_defs.svh
// Offsets, field positions, reset values and encodings of the word multiply unit
`ifndef WMU_DEFS_SVH
`define WMU_DEFS_SVH
`define WMU_OFF_INSN 12'h000
`define WMU_OFF_CORE_CTRL 12'h004
`define WMU_OFF_STATUS 12'h008
`define WMU_OFF_UNIT_STAT 12'h00c
`define WMU_OFF_ACCUMULATOR_A_LO 12'h010
`define WMU_OFF_ACCUMULATOR_A_HI 12'h014
`define WMU_OFF_ACCUMULATOR_B_LO 12'h018
`define WMU_OFF_ACCUMULATOR_B_HI 12'h01c
`define WMU_WREG_PAGE 6'h01
`define WMU_DMEM_BIT 10
`define WMU_OP_UNSIGNED 8'hb8
`define WMU_OP_SIGNED 8'hb9
`define WMU_F_SEL 15
`define WMU_F_BASE_LO 11
`define WMU_F_DST_LO 7
`define WMU_F_ACC 7
`define WMU_F_MODE_LO 4
`define WMU_ACC_MARK 3'b111
`define WMU_LIT_MARK 2'b11
`define WMU_AM_DIRECT 3'b000
`define WMU_AM_INDIRECT 3'b001
`define WMU_AM_POST_DEC 3'b010
`define WMU_AM_POST_INC 3'b011
`define WMU_AM_PRE_DEC 3'b100
`define WMU_AM_PRE_INC 3'b101
`define WMU_CC_IF 0
`define WMU_CC_SIGN_LO 12
`define WMU_PTR_STEP 16'h0002
`define WMU_RST_WORD 16'h0000
`define WMU_RST_INSN 24'h000000
`define WMU_RST_ACC 40'h0000000000
`define WMU_RST_COUNT 8'h00
`endif

// File: common/wmu_pkg.sv
// Types shared by the word multiply unit
`default_nettype none
package wmu_pkg;
	typedef enum logic [1:0]
	{
		wmu_kind_none = 2'b00,
		wmu_kind_acc_reg = 2'b01,
		wmu_kind_acc_lit = 2'b10,
		wmu_kind_word_ss = 2'b11
	} wmu_kind_t;
	typedef enum logic [1:0]
	{
		wmu_st_idle = 2'b00,
		wmu_st_exec = 2'b01
	} wmu_state_t;
endpackage : wmu_pkg
`default_nettype wire

// File: design/wmu_decode.sv
// Instruction decoder for the three multiply forms
`timescale 1ns/1ps
`default_nettype none
`include "wmu_defs.svh"
module wmu_decode
(
	// Instruction word
	input wire logic [23:0] insn,
	// Decoded fields
	output wmu_pkg::wmu_kind_t kind,
	output logic [3:0] base_sel,
	output logic [3:0] dst_sel,
	output logic [3:0] src_sel,
	output logic [2:0] src_mode,
	output logic acc_sel,
	output logic [4:0] lit
);
	logic is_unsigned;
	logic is_signed;
	logic acc_mark;
	logic lit_mark;
	logic mode_ok;
	// Only the two accumulator forms and the signed word form exist; any other pattern is left undecoded
	assign is_unsigned = (insn[23:16] == `WMU_OP_UNSIGNED) && !insn[`WMU_F_SEL];
	assign is_signed = (insn[23:16] == `WMU_OP_SIGNED) && insn[`WMU_F_SEL];
	assign acc_mark = insn[10:8] == `WMU_ACC_MARK;
	assign lit_mark = insn[6:5] == `WMU_LIT_MARK;
	assign mode_ok = insn[6:4] <= `WMU_AM_PRE_INC;
	assign kind = (is_unsigned && acc_mark && lit_mark) ? wmu_pkg::wmu_kind_acc_lit :
		(is_unsigned && acc_mark && mode_ok) ? wmu_pkg::wmu_kind_acc_reg :
		(is_signed && mode_ok) ? wmu_pkg::wmu_kind_word_ss : wmu_pkg::wmu_kind_none;
	assign base_sel = insn[`WMU_F_BASE_LO+3:`WMU_F_BASE_LO];
	assign dst_sel = insn[`WMU_F_DST_LO+3:`WMU_F_DST_LO];
	assign src_mode = insn[`WMU_F_MODE_LO+2:`WMU_F_MODE_LO];
	assign src_sel = insn[3:0];
	assign acc_sel = insn[`WMU_F_ACC];
	assign lit = insn[4:0];
endmodule : wmu_decode
`default_nettype wire

// File: design/wmu_mult.sv
// 16x16 multiplier giving the accumulator and the signed word results
`timescale 1ns/1ps
`default_nettype none
module wmu_mult
(
	// Operands
	input wire logic [15:0] base_val,
	input wire logic [15:0] src_val,
	input wire logic frac,
	// Results
	output logic [39:0] acc_val,
	output logic [15:0] word_val
);
	logic [31:0] uprod;
	logic signed [31:0] sprod;
	assign uprod = 32'(base_val) * 32'(src_val);
	// Fractional mode shifts the unsigned product left one place
	assign acc_val = frac ? {7'h00, uprod, 1'b0} : {8'h00, uprod};
	assign sprod = $signed({{16{base_val[15]}}, base_val})
		* $signed({{16{src_val[15]}}, src_val});
	assign word_val = sprod[15:0];
endmodule : wmu_mult
`default_nettype wire

// File: design/wmu_top.sv
// Word multiply unit with its register file, accumulators, data memory and APB slave
`timescale 1ns/1ps
`default_nettype none
`include "wmu_defs.svh"
module wmu_top
#(
	parameter int DMEM_AW = 8
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Execution status
	output logic exec_done,
	output logic illegal_insn
);
	localparam int DMEM_WORDS = 1 << DMEM_AW;

	function automatic logic [15:0] wmu_merge
	(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0] strb
	);
		wmu_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
	endfunction : wmu_merge

	// Architectural state
	logic [15:0] wreg [16];
	logic [15:0] next_wreg [16];
	logic [15:0] dmem [DMEM_WORDS];
	logic [39:0] accumulator_a;
	logic [39:0] accumulator_b;
	logic [15:0] core_control_register;
	logic [15:0] status_register;
	logic [23:0] insn;
	logic [7:0] exec_count;
	wmu_pkg::wmu_state_t state;

	// Bus decode
	logic apb_access;
	logic apb_wr;
	logic hit_insn;
	logic hit_cc;
	logic hit_status;
	logic hit_ustat;
	logic hit_accumulator_a_lo;
	logic hit_accumulator_a_hi;
	logic hit_accumulator_b_lo;
	logic hit_accumulator_b_hi;
	logic hit_w;
	logic hit_mem;
	logic addr_ok;
	logic [3:0] w_idx;
	logic [DMEM_AW-1:0] mem_idx;
	logic [31:0] rd_word;
	logic [15:0] unit_stat;

	assign apb_access = psel && penable;
	assign apb_wr = apb_access && pready && pwrite;
	assign hit_insn = paddr == `WMU_OFF_INSN;
	assign hit_cc = paddr == `WMU_OFF_CORE_CTRL;
	assign hit_status = paddr == `WMU_OFF_STATUS;
	assign hit_ustat = paddr == `WMU_OFF_UNIT_STAT;
	assign hit_accumulator_a_lo = paddr == `WMU_OFF_ACCUMULATOR_A_LO;
	assign hit_accumulator_a_hi = paddr == `WMU_OFF_ACCUMULATOR_A_HI;
	assign hit_accumulator_b_lo = paddr == `WMU_OFF_ACCUMULATOR_B_LO;
	assign hit_accumulator_b_hi = paddr == `WMU_OFF_ACCUMULATOR_B_HI;
	assign hit_w = (paddr[11:6] == `WMU_WREG_PAGE) && (paddr[1:0] == 2'b00);
	// Compare at full width: a 256-word depth does not fit an 8-bit bound
	assign hit_mem = paddr[`WMU_DMEM_BIT] && !paddr[11] && (paddr[1:0] == 2'b00)
		&& (int'(paddr[9:2]) < DMEM_WORDS);
	assign w_idx = paddr[5:2];
	assign mem_idx = paddr[DMEM_AW+1:2];
	assign addr_ok = hit_insn || hit_cc || hit_status || hit_ustat || hit_accumulator_a_lo
		|| hit_accumulator_a_hi || hit_accumulator_b_lo || hit_accumulator_b_hi || hit_w || hit_mem;
	assign unit_stat = {exec_count, 6'h00, illegal_insn, state == wmu_pkg::wmu_st_exec};
	assign rd_word = hit_insn ? {8'h00, insn} :
		hit_cc ? {16'h0000, core_control_register} :
		hit_status ? {16'h0000, status_register} :
		hit_ustat ? {16'h0000, unit_stat} :
		hit_accumulator_a_lo ? accumulator_a[31:0] :
		hit_accumulator_a_hi ? {24'h000000, accumulator_a[39:32]} :
		hit_accumulator_b_lo ? accumulator_b[31:0] :
		hit_accumulator_b_hi ? {24'h000000, accumulator_b[39:32]} :
		hit_w ? {16'h0000, wreg[w_idx]} :
		hit_mem ? {16'h0000, dmem[mem_idx]} : 32'h00000000;

	// Decoded instruction
	wmu_pkg::wmu_kind_t kind;
	logic [3:0] base_sel;
	logic [3:0] dst_sel;
	logic [3:0] src_sel;
	logic [2:0] src_mode;
	logic acc_sel;
	logic [4:0] lit;

	wmu_decode wmu_decode_inst
	(
		.insn(insn),
		.kind(kind),
		.base_sel(base_sel),
		.dst_sel(dst_sel),
		.src_sel(src_sel),
		.src_mode(src_mode),
		.acc_sel(acc_sel),
		.lit(lit)
	);

	// Operand fetch
	logic executing;
	logic is_lit;
	logic is_acc;
	logic is_word;
	logic is_pre;
	logic is_dec;
	logic ptr_upd;
	logic [15:0] base_val;
	logic [15:0] ptr_old;
	logic [15:0] ptr_new;
	logic [15:0] eff_addr;
	logic [15:0] mem_rd;
	logic [15:0] src_val;
	logic [39:0] acc_val;
	logic [15:0] word_val;

	assign executing = state == wmu_pkg::wmu_st_exec;
	assign is_lit = kind == wmu_pkg::wmu_kind_acc_lit;
	assign is_acc = is_lit || (kind == wmu_pkg::wmu_kind_acc_reg);
	assign is_word = kind == wmu_pkg::wmu_kind_word_ss;
	assign base_val = wreg[base_sel];
	assign ptr_old = wreg[src_sel];
	assign is_pre = (src_mode == `WMU_AM_PRE_DEC) || (src_mode == `WMU_AM_PRE_INC);
	assign is_dec = (src_mode == `WMU_AM_PRE_DEC) || (src_mode == `WMU_AM_POST_DEC);
	assign ptr_new = is_dec ? ptr_old - `WMU_PTR_STEP : ptr_old + `WMU_PTR_STEP;
	assign eff_addr = is_pre ? ptr_new : ptr_old;
	// Word addressing: the byte address drops bit 0; high bits wrap into the memory
	assign mem_rd = dmem[eff_addr[DMEM_AW:1]];
	assign src_val = is_lit ? {11'h000, lit} :
		(src_mode == `WMU_AM_DIRECT) ? ptr_old : mem_rd;
	assign ptr_upd = executing && !is_lit && (kind != wmu_pkg::wmu_kind_none)
		&& (src_mode != `WMU_AM_DIRECT) && (src_mode != `WMU_AM_INDIRECT);

	// Sign mode bits are never routed to the multiplier
	wmu_mult wmu_mult_inst
	(
		.base_val(base_val),
		.src_val(src_val),
		.frac(core_control_register[`WMU_CC_IF] && is_acc),
		.acc_val(acc_val),
		.word_val(word_val)
	);

	// Working register next values: result beats pointer update beats bus write
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_wreg
			logic [15:0] raw;
			assign raw = (executing && is_word && (dst_sel == 4'(gi))) ? word_val :
				(ptr_upd && (src_sel == 4'(gi))) ? ptr_new :
				(apb_wr && hit_w && (w_idx == 4'(gi))) ? wmu_merge(wreg[gi], pwdata, pstrb) :
				wreg[gi];
			// The top pointer register has bit 0 tied low
			if (gi == 15)
			begin : g_sp
				assign next_wreg[gi] = {raw[15:1], 1'b0};
			end
			else
			begin : g_gp
				assign next_wreg[gi] = raw;
			end
			always_ff @(posedge mclk)
			begin
				if (srst)
					wreg[gi] <= `WMU_RST_WORD;
				else
					wreg[gi] <= next_wreg[gi];
			end
		end
	endgenerate

	// Accumulator next values
	logic [39:0] next_acc_a;
	logic [39:0] next_acc_b;
	logic [39:0] bus_acc_a;
	logic [39:0] bus_acc_b;

	assign bus_acc_a = hit_accumulator_a_lo ?
		{accumulator_a[39:32], wmu_merge(accumulator_a[31:16], {16'h0000, pwdata[31:16]},
		{2'b00, pstrb[3:2]}), wmu_merge(accumulator_a[15:0], pwdata, pstrb)} :
		{pstrb[0] ? pwdata[7:0] : accumulator_a[39:32], accumulator_a[31:0]};
	assign bus_acc_b = hit_accumulator_b_lo ?
		{accumulator_b[39:32], wmu_merge(accumulator_b[31:16], {16'h0000, pwdata[31:16]},
		{2'b00, pstrb[3:2]}), wmu_merge(accumulator_b[15:0], pwdata, pstrb)} :
		{pstrb[0] ? pwdata[7:0] : accumulator_b[39:32], accumulator_b[31:0]};
	assign next_acc_a = (executing && is_acc && !acc_sel) ? acc_val :
		(apb_wr && (hit_accumulator_a_lo || hit_accumulator_a_hi)) ? bus_acc_a : accumulator_a;
	assign next_acc_b = (executing && is_acc && acc_sel) ? acc_val :
		(apb_wr && (hit_accumulator_b_lo || hit_accumulator_b_hi)) ? bus_acc_b : accumulator_b;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			accumulator_a <= `WMU_RST_ACC;
			accumulator_b <= `WMU_RST_ACC;
		end
		else
		begin
			accumulator_a <= next_acc_a;
			accumulator_b <= next_acc_b;
		end
	end

	// Control and status registers; multiplies never touch the status flags
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			core_control_register <= `WMU_RST_WORD;
			status_register <= `WMU_RST_WORD;
		end
		else
		begin
			if (apb_wr && hit_cc)
				core_control_register <= wmu_merge(core_control_register, pwdata, pstrb);
			if (apb_wr && hit_status)
				status_register <= wmu_merge(status_register, pwdata, pstrb);
		end
	end

	// Data memory is written only by the bus; reads are combinational
	always_ff @(posedge mclk)
	begin
		if (apb_wr && hit_mem)
			dmem[mem_idx] <= wmu_merge(dmem[mem_idx], pwdata, pstrb);
	end

	// Sequencer: a write of the instruction word starts one execute cycle
	logic start;
	wmu_pkg::wmu_state_t next_state;

	assign start = apb_wr && hit_insn;
	// The bus holds off during the execute cycle, so a start cannot arrive there
	always_comb
	begin
		case (state)
			wmu_pkg::wmu_st_idle:
				next_state = start ? wmu_pkg::wmu_st_exec : wmu_pkg::wmu_st_idle;
			wmu_pkg::wmu_st_exec:
				next_state = wmu_pkg::wmu_st_idle;
			default:
				next_state = wmu_pkg::wmu_st_idle;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			state <= wmu_pkg::wmu_st_idle;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			insn <= `WMU_RST_INSN;
		else if (start)
			insn <= {pstrb[2] ? pwdata[23:16] : insn[23:16], wmu_merge(insn[15:0], pwdata, pstrb)};
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			exec_done <= 1'b0;
			illegal_insn <= 1'b0;
			exec_count <= `WMU_RST_COUNT;
		end
		else
		begin
			exec_done <= executing;
			if (executing)
			begin
				illegal_insn <= kind == wmu_pkg::wmu_kind_none;
				exec_count <= exec_count + 8'h01;
			end
		end
	end

	// APB response: one wait state, and none is granted while a multiply executes
	logic give_ready;

	assign give_ready = apb_access && !pready && !executing;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= give_ready;
			if (give_ready)
			begin
				prdata <= (pwrite || !addr_ok) ? 32'h00000000 : rd_word;
				pslverr <= !addr_ok;
			end
			else
			begin
				prdata <= 32'h00000000;
				pslverr <= 1'b0;
			end
		end
	end
endmodule : wmu_top
`default_nettype wire

// File: testbench/tb_wmu_top.sv
// Self-checking bench for the word multiply unit
`timescale 1ns/1ps
`default_nettype none
`include "wmu_defs.svh"
module tb_wmu_top;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, exec_done, illegal_insn;
	logic [32:0] q_rd[$];
	logic q_ill[$];
	logic [15:0] seed = 16'h0035;
	logic [7:0] cnt = 8'h00;
	logic [39:0] accv[2] = '{40'h0, 40'h0};
	int errors = 0;
	int compares = 0;
	always #5 mclk = ~mclk;
	wmu_top #(.DMEM_AW(8)) wmu_top_inst (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.exec_done(exec_done), .illegal_insn(illegal_insn));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	function automatic logic [11:0] wa(input logic [3:0] n);
		return 12'h040 + {6'h00, n, 2'b00};
	endfunction : wa
	task automatic summarize();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic chk_rd(input logic [32:0] e);
		compares++;
		if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0]))
		begin
			errors++;
			$display("[ERR] apb %h exp %h got %h", paddr, e, {pslverr, prdata});
		end
	endtask : chk_rd
	task automatic chk_ill(input logic e);
		compares++;
		if (illegal_insn !== e)
		begin
			errors++;
			$display("[ERR] illegal_insn exp %b got %b", e, illegal_insn);
		end
	endtask : chk_ill
	task automatic chk_lat(input int n);
		compares++;
		if (n != 2)
		begin
			errors++;
			$display("[ERR] exec_done latency exp 2 got %0d", n);
		end
	endtask : chk_lat
	// Expected answer queued before the request so the monitor never runs dry
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		q_rd.push_back(e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask : rd
	task automatic run(input logic [23:0] i, input logic ill);
		int n;
		q_ill.push_back(ill);
		cnt++;
		wr(`WMU_OFF_INSN, {8'h00, i});
		n = 0;
		while (exec_done !== 1'b1 && n < 10)
		begin
			@(posedge mclk);
			n++;
		end
		chk_lat(n);
	endtask : run
	task automatic rdacc();
		for (int k = 0; k < 2; k++)
		begin
			rd(12'h010 + {8'h0, k[0], 3'b000}, accv[k][31:0]);
			rd(12'h014 + {8'h0, k[0], 3'b000}, {24'h0, accv[k][39:32]});
		end
	endtask : rdacc
	always @(posedge mclk)
	begin
		if (psel && penable && pready === 1'b1)
			chk_rd(q_rd.pop_front());
		if (exec_done === 1'b1)
			chk_ill(q_ill.pop_front());
	end
	initial
	begin
		#50us;
		errors++;
		summarize();
	end
	initial
	begin
		logic [15:0] a, b, m, p, q, e;
		logic [4:0] k;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		rd(`WMU_OFF_CORE_CTRL, 32'h0);
		rd(`WMU_OFF_UNIT_STAT, 32'h0);
		rdacc();
		apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 12'h03c, 32'h1, {1'b1, 32'h0});
		wr(`WMU_OFF_STATUS, 32'h00a5);
		// Bit 0 picks accumulator, bit 1 literal form, bit 2 fractional mode
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			a = seed;
			seed = lfsr(seed);
			b = seed;
			k = (i == 2) ? 5'h1f : (i == 6) ? 5'h00 : b[4:0];
			m = i[1] ? {11'h0, k} : b;
			wr(`WMU_OFF_CORE_CTRL, {18'h0, b[1:0], 11'h0, i[2]});
			wr(wa(3), {16'h0, a});
			wr(wa(5), {16'h0, b});
			if (i[1])
				run({8'hb8, 1'b0, 4'h3, 3'b111, i[0], 2'b11, k}, 1'b0);
			else
				run({8'hb8, 1'b0, 4'h3, 3'b111, i[0], 3'b000, 4'h5}, 1'b0);
			accv[i[0]] = ({24'h0, a} * {24'h0, m}) << i[2];
			rdacc();
		end
		rd(`WMU_OFF_STATUS, 32'h00a5);
		rd(`WMU_OFF_UNIT_STAT, {16'h0, cnt, 8'h00});
		wr(`WMU_OFF_CORE_CTRL, 32'h3001);
		// Every source mode of the signed word form, fraction and sign mode set
		for (int md = 0; md < 6; md++)
		begin
			seed = lfsr(seed);
			a = seed;
			seed = lfsr(seed);
			b = seed;
			p = {6'h0, a[9:2], 2'b10};
			q = (md == 2 || md == 4) ? p - 16'h2 : (md == 3 || md == 5) ? p + 16'h2 : p;
			e = (md >= 4) ? q : p;
			m = (md == 0) ? p : b;
			wr(wa(2), {16'h0, a});
			wr(wa(1), {16'h0, p});
			wr(12'h400 + {2'b00, e[8:1], 2'b00}, {16'h0, b});
			run({8'hb9, 1'b1, 4'h2, 4'h4, md[2:0], 4'h1}, 1'b0);
			rd(wa(4), {16'h0, 16'(a * m)});
			rd(wa(1), {16'h0, q});
		end
		run({8'hb9, 1'b1, 4'h2, 4'h4, 3'b110, 4'h1}, 1'b1);
		run(24'h000000, 1'b1);
		run({8'hb8, 1'b0, 4'h3, 4'h2, 3'b000, 4'h5}, 1'b1);
		run({8'hb8, 1'b0, 4'h3, 3'b111, 1'b0, 2'b11, 5'h01}, 1'b0);
		repeat (3) @(posedge mclk);
		summarize();
	end
endmodule : tb_wmu_top
`default_nettype wire

// File: testbench/wmu_props.sv
// Port checker for the word multiply unit
`timescale 1ns/1ps
`default_nettype none
`include "wmu_defs.svh"
module wmu_props
#(
	parameter int DMEM_AW = 8
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status
	input wire logic exec_done,
	input wire logic illegal_insn
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	wire logic xfer;
	wire logic iwr;
	assign xfer = psel && penable && pready;
	assign iwr = xfer && pwrite && paddr == `WMU_OFF_INSN && !pslverr;
	AST_RDY_ACCESS: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	AST_RDY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_RDY_BOUND: assert property (psel && penable && !$past(penable) |-> ##[1:2] pready)
		else $error("pready late");
	AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero when idle");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_UNMAPPED: assert property (xfer && paddr inside {[12'h020:12'h03c]} |-> pslverr)
		else $error("hole not refused");
	AST_EXEC_ONE: assert property (iwr |=> !exec_done ##1 exec_done ##1 !exec_done)
		else $error("execute not single cycle");
	AST_DONE_CAUSE: assert property (exec_done |-> $past(iwr, 2))
		else $error("exec_done without instruction");
	AST_ILL_HOLD: assert property (!exec_done |-> $stable(illegal_insn))
		else $error("illegal flag moved");
	AST_STAT_ILL: assert property (xfer && !pwrite && paddr == `WMU_OFF_UNIT_STAT
		&& !exec_done |-> prdata[1] == illegal_insn)
		else $error("status bit and flag differ");
	C_EXEC: cover property (iwr);
	C_ILL: cover property (exec_done && illegal_insn);
	C_ERR: cover property (xfer && pslverr);
endmodule : wmu_props
bind wmu_top wmu_props #(.DMEM_AW(DMEM_AW)) wmu_props_inst (.mclk(mclk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.exec_done(exec_done), .illegal_insn(illegal_insn));
`default_nettype wire
